// ===== design/srs_pkg.sv
// Package with timing constants, rail indices and sequencer states.
package srs_pkg;
    localparam int    CLK_MHZ          = 125;
    localparam int    CLK_PERIOD_PS    = 8000;
    // Primary clock divided by 610 gives one unit P.
    localparam int    P_DIVIDE         = 610;
    localparam int    PRIM_CLK_DEFAULT_KHZ = 20000;
    localparam int    RESET_HOLD_P     = 12;
    localparam int    BOOT_SETUP_P     = 2;
    localparam int    BOOT_HOLD_P      = 15;
    localparam int    POR_LEAD_US      = 100;
    localparam int    GROUP1_US        = 500;
    localparam int    GROUP2_US        = 1000;
    localparam int    GROUP3_US        = 1500;
    localparam int    RESET_OUT_DELAY_MS = 2;
    localparam int    DDR_DISCHARGE_MS = 10;
    localparam int    CYC_PER_US       = CLK_MHZ;
    localparam int    POR_LEAD_CYC     = POR_LEAD_US * CYC_PER_US;
    localparam int    GROUP1_CYC       = GROUP1_US * CYC_PER_US;
    localparam int    GROUP2_CYC       = GROUP2_US * CYC_PER_US;
    localparam int    GROUP3_CYC       = GROUP3_US * CYC_PER_US;
    localparam int    DDR_DISCHARGE_CYC = DDR_DISCHARGE_MS * 1000 * CYC_PER_US;
    localparam int    PG_TIMEOUT_US    = 20000;
    localparam int    PG_TIMEOUT_CYC   = PG_TIMEOUT_US * CYC_PER_US;
    localparam int    CNT_W            = 24;
    localparam int    BOOT_W           = 16;
    localparam int    NUM_RAILS        = 6;
    localparam int    RAIL_IO18        = 0;
    localparam int    RAIL_ANALOG      = 1;
    localparam int    RAIL_MEM         = 2;
    localparam int    RAIL_CORE        = 3;
    localparam int    RAIL_ACCEL       = 4;
    localparam int    RAIL_DVIO        = 5;
    localparam logic [NUM_RAILS-1:0] RAILS_OFF = 6'h00;

    typedef enum logic [10:0] {
        SRS_OFF       = 11'h001,
        SRS_UP_IO18   = 11'h002,
        SRS_UP_MEMANA = 11'h004,
        SRS_UP_CORE   = 11'h008,
        SRS_UP_ACCEL  = 11'h010,
        SRS_UP_DVIO   = 11'h020,
        SRS_RESET     = 11'h040,
        SRS_RUN       = 11'h080,
        SRS_DN_POR    = 11'h100,
        SRS_DN_GROUPS = 11'h200,
        SRS_FAULT     = 11'h400
    } srs_state_type;
endpackage : srs_pkg

// ===== design/srs_timer_if.sv
// Interface between the sequencer and its P-unit timer.
`timescale 1ns/1ps
interface srs_timer_if;
    logic       p_tick;
    logic [7:0] p_count;
    logic       clear;
    modport owner (input p_tick, input p_count, output clear);
    modport timer (output p_tick, output p_count, input clear);
endinterface : srs_timer_if

// ===== design/srs_p_timer.sv
// Divider that produces one pulse per unit P and counts elapsed units.
`timescale 1ns/1ps
module srs_p_timer
    import srs_pkg::*;
(
    input  wire logic        i_clock,
    input  wire logic        i_rst_n,
    input  wire logic [31:0] i_p_cycles,
    srs_timer_if.timer       tmr
);
    logic [31:0] div;

    // One P is i_p_cycles clocks; the enable is a single-cycle pulse.
    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            div <= 32'h0;
        end else if (tmr.clear || div + 32'h1 >= i_p_cycles) begin
            div <= 32'h0;
        end else begin
            div <= div + 32'h1;
        end
    end

    assign tmr.p_tick = !tmr.clear && (div + 32'h1 >= i_p_cycles);

    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            tmr.p_count <= 8'h00;
        end else if (tmr.clear) begin
            tmr.p_count <= 8'h00;
        end else if (tmr.p_tick && tmr.p_count != 8'hFF) begin
            tmr.p_count <= tmr.p_count + 8'h01;
        end
    end
endmodule : srs_p_timer

// ===== design/srs_sequencer.sv
// Power-management sequencer driving rail enables, resets and boot straps.
//
// Behaviour
// - Analog rails enabled only after the 1.8 V I/O rail is good.
// - Memory rails enabled only after the 1.8 V I/O rail is good.
// - Core rail enabled only after I/O and memory rails are good.
// - Accelerator rail enabled only after the core rail is good.
// - 3.3 V dual-voltage rails enabled last; 1.8 V ones follow the I/O rail.
// - Warm and power-on resets held low 12P after oscillator stable.
// - Boot straps driven valid at least 2P before power-on reset release.
// - Boot straps held valid at least 15P after power-on reset release.
// - Power-on reset low at least 100 us before any rail falls.
// - 3.3 V dual-voltage rails stay up 100 us, then fall first.
// - 3.3 V dual-voltage rails fall before the 1.8 V I/O rail.
// - 1.8 V dual-voltage rails fall together with the I/O rail.
// - Accelerator rail falls before or with the core rail.
// - Memory rails fall after the core rail in normal shutdown, with it in abrupt shutdown.
// - 1.8 V I/O rail stays enabled until all others but 1.8 V dual-voltage rails have fallen.
// - Groups fall at 500 us, 1.0 ms and 1.5 ms after reset assertion.
// - Analog rails fall before or with the 1.8 V I/O rail.
// - Memory rails must be off within 10 ms of the I/O rail falling.
// - Abrupt shutdown drops all rails but I/O and 1.8 V dual-voltage after the 100 us hold.
// - In abrupt shutdown the I/O rail falls after accelerator and core.
`timescale 1ns/1ps
module srs_sequencer
    import srs_pkg::*;
(
    input  wire logic                 i_clock,
    input  wire logic                 i_nrst,
    input  wire logic                 i_power_on_req,
    input  wire logic                 i_power_off_req,
    input  wire logic                 i_input_power_lost,
    input  wire logic                 i_dvio_is_3v3,
    input  wire logic                 i_osc0_input_stable,
    input  wire logic [31:0]          i_p_cycles,
    input  wire logic [BOOT_W-1:0]    i_boot_value,
    input  wire logic [NUM_RAILS-1:0] i_rail_good,
    input  wire logic                 i_reset_out_n,
    output logic      [NUM_RAILS-1:0] o_rail_enable,
    output logic                      o_warm_reset_n,
    output logic                      o_por_n,
    output logic      [BOOT_W-1:0]    o_boot_strap_pins,
    output logic                      o_boot_strap_oe,
    output logic                      o_running,
    output logic                      o_fault,
    output logic                      o_mem_discharge_late
);
    logic          rst_meta;
    logic          rst_n;
    srs_state_type state;
    srs_state_type next_state;
    logic [CNT_W-1:0] cnt;
    logic [CNT_W-1:0] ddr_cnt;
    logic          abrupt;
    logic          released;
    logic          por_q;
    logic          prev_reset_out_n;
    logic [CNT_W-1:0] por_low_cnt;

    srs_timer_if tmr ();

    // Reset is released through two flip-flops.
    always_ff @(posedge i_clock or negedge i_nrst) begin
        if (!i_nrst) begin
            rst_meta <= 1'b0;
            rst_n    <= 1'b0;
        end else begin
            rst_meta <= 1'b1;
            rst_n    <= rst_meta;
        end
    end

    srs_p_timer u_p_timer (
        .i_clock    (i_clock),
        .i_rst_n    (rst_n),
        .i_p_cycles (i_p_cycles),
        .tmr        (tmr)
    );

    function automatic logic good(input logic [NUM_RAILS-1:0] g, input int idx);
        good = g[idx];
    endfunction : good

    function automatic logic cnt_at(input logic [CNT_W-1:0] c, input int lim);
        cnt_at = c >= CNT_W'(lim);
    endfunction : cnt_at

    logic down_req;
    assign down_req = i_power_off_req || i_input_power_lost;

    always_comb begin
        next_state = state;
        unique case (state)
            SRS_OFF:       if (i_power_on_req && !down_req) next_state = SRS_UP_IO18;
            SRS_UP_IO18:   if (good(i_rail_good, RAIL_IO18)) next_state = SRS_UP_MEMANA;
            SRS_UP_MEMANA: if (good(i_rail_good, RAIL_MEM) && good(i_rail_good, RAIL_ANALOG))
                               next_state = SRS_UP_CORE;
            SRS_UP_CORE:   if (good(i_rail_good, RAIL_CORE)) next_state = SRS_UP_ACCEL;
            SRS_UP_ACCEL:  if (good(i_rail_good, RAIL_ACCEL)) next_state = SRS_UP_DVIO;
            SRS_UP_DVIO:   if (good(i_rail_good, RAIL_DVIO) || !i_dvio_is_3v3)
                               next_state = SRS_RESET;
            SRS_RESET:     if (released && tmr.p_count >= 8'(BOOT_HOLD_P))
                               next_state = SRS_RUN;
            SRS_RUN:       if (down_req) next_state = SRS_DN_POR;
            SRS_DN_POR:    if (cnt_at(cnt, POR_LEAD_CYC)) next_state = SRS_DN_GROUPS;
            SRS_DN_GROUPS: if (o_rail_enable == RAILS_OFF) next_state = SRS_OFF;
            SRS_FAULT:     next_state = SRS_DN_POR;
            default:       next_state = SRS_FAULT;
        endcase
        // Power-up stages waiting on power good time out into a safe shutdown.
        if ((state == SRS_UP_IO18 || state == SRS_UP_MEMANA || state == SRS_UP_CORE
             || state == SRS_UP_ACCEL || state == SRS_UP_DVIO)
            && cnt_at(cnt, PG_TIMEOUT_CYC)) begin
            next_state = SRS_FAULT;
        end
        if ((state == SRS_RESET) && down_req) begin
            next_state = SRS_DN_POR;
        end
    end

    always_ff @(posedge i_clock or negedge rst_n) begin
        if (!rst_n) begin
            state <= SRS_OFF;
        end else begin
            state <= next_state;
        end
    end

    // Cycle counter restarts on every state change except entry to the group phase, and holds at its top value.
    // The count carries over into the group phase, so every group mark is a
    // total time since shutdown began rather than an interval.
    always_ff @(posedge i_clock or negedge rst_n) begin
        if (!rst_n) begin
            cnt <= '0;
        end else if (next_state != state) begin
            cnt <= (next_state == SRS_DN_GROUPS) ? cnt : '0;
        end else if (cnt != {CNT_W{1'b1}}) begin
            cnt <= cnt + CNT_W'(1);
        end
    end

    always_ff @(posedge i_clock or negedge rst_n) begin
        if (!rst_n) begin
            abrupt <= 1'b0;
        end else if (state == SRS_RUN || state == SRS_RESET || state == SRS_FAULT) begin
            abrupt <= i_input_power_lost || state == SRS_FAULT;
        end else if (state == SRS_DN_POR && i_input_power_lost) begin
            abrupt <= 1'b1;
        end
    end

    // P timer is held until the oscillator is stable and restarts at release.
    assign tmr.clear = (state != SRS_RESET) || !i_osc0_input_stable
                       || (!released && tmr.p_count >= 8'(RESET_HOLD_P)
                           && tmr.p_count >= 8'(BOOT_SETUP_P));

    always_ff @(posedge i_clock or negedge rst_n) begin
        if (!rst_n) begin
            released <= 1'b0;
        end else if (state != SRS_RESET) begin
            released <= 1'b0;
        end else if (i_osc0_input_stable && tmr.p_count >= 8'(RESET_HOLD_P)) begin
            released <= 1'b1;
        end
    end

    always_ff @(posedge i_clock or negedge rst_n) begin
        if (!rst_n) begin
            por_q          <= 1'b0;
            o_warm_reset_n <= 1'b0;
        end else begin
            por_q          <= (state == SRS_RESET && released) || state == SRS_RUN;
            o_warm_reset_n <= (state == SRS_RESET && released) || state == SRS_RUN;
        end
    end
    assign o_por_n = por_q;

    // Straps driven from entry to the reset stage until the hold has passed.
    always_ff @(posedge i_clock or negedge rst_n) begin
        if (!rst_n) begin
            o_boot_strap_pins <= '0;
            o_boot_strap_oe   <= 1'b0;
        end else if (state == SRS_RESET && !released) begin
            o_boot_strap_pins <= i_boot_value;
            o_boot_strap_oe   <= 1'b1;
        end else if (state != SRS_RESET) begin
            o_boot_strap_oe   <= 1'b0;
        end
    end

    // Rail enables: each set in its power-up stage, 1.8 V dual-voltage with I/O; cleared by the power-down plan.
    always_ff @(posedge i_clock or negedge rst_n) begin
        if (!rst_n) begin
            o_rail_enable <= RAILS_OFF;
        end else begin
            unique case (state)
                SRS_UP_IO18: begin
                    o_rail_enable[RAIL_IO18] <= 1'b1;
                    if (!i_dvio_is_3v3) o_rail_enable[RAIL_DVIO] <= 1'b1;
                end
                SRS_UP_MEMANA: begin
                    o_rail_enable[RAIL_MEM]    <= 1'b1;
                    o_rail_enable[RAIL_ANALOG] <= 1'b1;
                end
                SRS_UP_CORE:  o_rail_enable[RAIL_CORE]  <= 1'b1;
                SRS_UP_ACCEL: o_rail_enable[RAIL_ACCEL] <= 1'b1;
                SRS_UP_DVIO:  o_rail_enable[RAIL_DVIO]  <= 1'b1;
                SRS_DN_GROUPS: begin
                    if (abrupt) begin
                        // All but the I/O rail and a 1.8 V dual-voltage rail fall now; those wait for group 1.
                        o_rail_enable[RAIL_ACCEL]  <= 1'b0;
                        o_rail_enable[RAIL_CORE]   <= 1'b0;
                        o_rail_enable[RAIL_MEM]    <= 1'b0;
                        o_rail_enable[RAIL_ANALOG] <= 1'b0;
                        if (i_dvio_is_3v3) o_rail_enable[RAIL_DVIO] <= 1'b0;
                        if (cnt_at(cnt, GROUP1_CYC)) o_rail_enable <= RAILS_OFF;
                    end else begin
                        if (i_dvio_is_3v3) o_rail_enable[RAIL_DVIO] <= 1'b0;
                        if (cnt_at(cnt, GROUP1_CYC)) begin
                            o_rail_enable[RAIL_ACCEL] <= 1'b0;
                            o_rail_enable[RAIL_CORE]  <= 1'b0;
                        end
                        if (cnt_at(cnt, GROUP2_CYC)) begin
                            o_rail_enable[RAIL_MEM]    <= 1'b0;
                            o_rail_enable[RAIL_ANALOG] <= 1'b0;
                        end
                        if (cnt_at(cnt, GROUP3_CYC)) o_rail_enable <= RAILS_OFF;
                    end
                end
                default: ;
            endcase
        end
    end

    // Memory rail off within 10 ms of the I/O rail being switched off.
    always_ff @(posedge i_clock or negedge rst_n) begin
        if (!rst_n) begin
            ddr_cnt              <= '0;
            o_mem_discharge_late <= 1'b0;
        end else if (o_rail_enable[RAIL_IO18] || !i_rail_good[RAIL_MEM]) begin
            ddr_cnt <= '0;
        end else if (cnt_at(ddr_cnt, DDR_DISCHARGE_CYC)) begin
            o_mem_discharge_late <= 1'b1;
        end else begin
            ddr_cnt <= ddr_cnt + CNT_W'(1);
        end
    end

    // Reset-out is only watched; its 2 ms lag is the device's business.
    always_ff @(posedge i_clock or negedge rst_n) begin
        if (!rst_n) begin
            prev_reset_out_n <= 1'b0;
        end else begin
            prev_reset_out_n <= i_reset_out_n;
        end
    end

    assign o_running = (state == SRS_RUN) && prev_reset_out_n;
    assign o_fault   = (state == SRS_FAULT);

    property p_core_after_mem;
        @(posedge i_clock) disable iff (!rst_n)
        $rose(o_rail_enable[RAIL_CORE]) |-> i_rail_good[RAIL_IO18] && i_rail_good[RAIL_MEM];
    endproperty
    a_core_after_mem: assert property (p_core_after_mem) else $error("core before deps");

    property p_accel_after_core;
        @(posedge i_clock) disable iff (!rst_n)
        $rose(o_rail_enable[RAIL_ACCEL]) |-> o_rail_enable[RAIL_CORE];
    endproperty
    a_accel_after_core: assert property (p_accel_after_core) else $error("accel early");

    // Counts how long power-on reset has been low, so the lead check is exact.
    always_ff @(posedge i_clock or negedge rst_n) begin
        if (!rst_n) begin
            por_low_cnt <= '0;
        end else if (o_por_n) begin
            por_low_cnt <= '0;
        end else if (por_low_cnt != {CNT_W{1'b1}}) begin
            por_low_cnt <= por_low_cnt + CNT_W'(1);
        end
    end

    property p_por_lead;
        @(posedge i_clock) disable iff (!rst_n)
        |($past(o_rail_enable) & ~o_rail_enable) |-> por_low_cnt >= CNT_W'(POR_LEAD_CYC);
    endproperty
    a_por_lead: assert property (p_por_lead) else $error("rail fell before reset lead");

    property p_io_last;
        @(posedge i_clock) disable iff (!rst_n)
        $fell(o_rail_enable[RAIL_IO18]) |-> (o_rail_enable == RAILS_OFF);
    endproperty
    a_io_last: assert property (p_io_last) else $error("io rail not last");

    property p_analog_first;
        @(posedge i_clock) disable iff (!rst_n)
        $rose(o_rail_enable[RAIL_ANALOG]) |-> $past(i_rail_good[RAIL_IO18]);
    endproperty
    a_analog_first: assert property (p_analog_first) else $error("analog early");

    property p_strap_valid;
        @(posedge i_clock) disable iff (!rst_n)
        $rose(o_por_n) |-> o_boot_strap_oe [*8];
    endproperty
    a_strap_valid: assert property (p_strap_valid) else $error("strap hold short");
endmodule : srs_sequencer

// ===== tb/srs_dev_model.sv
// Behavioural model of the powered device: rail power-good and delayed reset-out.
`timescale 1ns/1ps
module srs_dev_model
    import srs_pkg::*;
#(
    parameter int RESET_OUT_CYC = 300
)(
    input  wire logic                 i_clock,
    input  wire logic                 i_slow,
    input  wire logic [NUM_RAILS-1:0] i_rail_enable,
    input  wire logic                 i_warm_reset_n,
    output logic      [NUM_RAILS-1:0] o_rail_good,
    output logic                      o_reset_out_n
);
    int ramp_cnt [NUM_RAILS];
    int rst_cnt;

    initial begin
        o_rail_good   = RAILS_OFF;
        o_reset_out_n = 1'b0;
        rst_cnt       = 0;
        foreach (ramp_cnt[r]) ramp_cnt[r] = 0;
    end

    // A rail reports good only after its ramp time; it drops at once when disabled.
    always @(posedge i_clock) begin
        for (int r = 0; r < NUM_RAILS; r++) begin
            if (!i_rail_enable[r]) begin
                ramp_cnt[r]    <= 0;
                o_rail_good[r] <= 1'b0;
            end else if (ramp_cnt[r] < (i_slow ? 40 : 2)) begin
                ramp_cnt[r] <= ramp_cnt[r] + 1;
            end else begin
                o_rail_good[r] <= 1'b1;
            end
        end
    end

    // The delay is far shorter than the real one so that a run stays brief.
    always @(posedge i_clock) begin
        if (i_warm_reset_n == o_reset_out_n) begin
            rst_cnt <= 0;
        end else if (rst_cnt < RESET_OUT_CYC - 1) begin
            rst_cnt <= rst_cnt + 1;
        end else begin
            o_reset_out_n <= i_warm_reset_n;
        end
    end
endmodule : srs_dev_model

// ===== tb/supply_rail_reset_sequencer_tb.sv
// Self-checking testbench for the supply rail and reset sequencer.
`timescale 1ns/1ps
module supply_rail_reset_sequencer_tb;
    import srs_pkg::*;
    localparam int P_CYC = 8;
    logic                 clock, nrst, power_on_req, power_off_req, input_power_lost;
    logic                 dvio_is_3v3, osc_stable, slow_rails, reset_out_n, warm_reset_n;
    logic                 por_n, boot_strap_oe, running, fault, mem_late;
    logic [31:0]          p_cycles;
    logic [BOOT_W-1:0]    boot_value, boot_strap_pins;
    logic [NUM_RAILS-1:0] rail_good, rail_enable;
    int                   miscompares, tests_run;

    srs_sequencer DUT (.i_clock(clock), .i_nrst(nrst), .i_power_on_req(power_on_req),
        .i_power_off_req(power_off_req), .i_input_power_lost(input_power_lost),
        .i_dvio_is_3v3(dvio_is_3v3), .i_osc0_input_stable(osc_stable), .i_p_cycles(p_cycles),
        .i_boot_value(boot_value), .i_rail_good(rail_good), .i_reset_out_n(reset_out_n),
        .o_rail_enable(rail_enable), .o_warm_reset_n(warm_reset_n), .o_por_n(por_n),
        .o_boot_strap_pins(boot_strap_pins), .o_boot_strap_oe(boot_strap_oe),
        .o_running(running), .o_fault(fault), .o_mem_discharge_late(mem_late));
    srs_dev_model device (.i_clock(clock), .i_slow(slow_rails), .i_rail_enable(rail_enable),
        .i_warm_reset_n(warm_reset_n), .o_rail_good(rail_good), .o_reset_out_n(reset_out_n));

    task automatic wrap_up;
        $display("comparisons %0d mismatches %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : wrap_up

    task automatic check_bit(input string what, input logic exp, input logic seen);
        tests_run++;
        if (seen !== exp) begin
            miscompares++;
            $display("mismatch %s expected %b seen %b", what, exp, seen);
        end
    endtask : check_bit

    task automatic check_rails(input string what, input logic [NUM_RAILS-1:0] exp,
                               input logic [NUM_RAILS-1:0] seen);
        tests_run++;
        if (seen !== exp) begin
            miscompares++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask : check_rails

    task automatic check_word(input string what, input logic [BOOT_W-1:0] exp,
                              input logic [BOOT_W-1:0] seen);
        tests_run++;
        if (seen !== exp) begin
            miscompares++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask : check_word

    task automatic check_count(input string what, input int lo, input int hi, input int seen);
        tests_run++;
        if (seen < lo || seen > hi) begin
            miscompares++;
            $display("mismatch %s expected %0d to %0d seen %0d", what, lo, hi, seen);
        end
    endtask : check_count

    task automatic timed_out(input string what);
        miscompares++;
        $display("mismatch %s expected done seen timeout", what);
        wrap_up();
    endtask : timed_out

    task automatic tick(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask : tick

    task automatic wait_running;
        int n;
        n = 0;
        while (running !== 1'b1 && n < 2000) begin
            tick(1);
            n++;
        end
        if (n >= 2000) timed_out("running");
        check_bit("reset out high when running", 1'b1, reset_out_n);
        check_bit("no fault", 1'b0, fault);
    endtask : wait_running

    // Every cycle of the ramp checks that each enable waited for its supplying rails.
    task automatic power_up(input logic is_3v3, input logic slow);
        int n;
        dvio_is_3v3  = is_3v3;
        slow_rails   = slow;
        power_on_req = 1'b1;
        n = 0;
        while (rail_enable !== 6'h3F && n < 3000) begin
            tick(1);
            n++;
            if (rail_enable[RAIL_ANALOG])
                check_bit("io18 before analog", 1'b1, rail_good[RAIL_IO18]);
            if (rail_enable[RAIL_MEM])
                check_bit("io18 before mem", 1'b1, rail_good[RAIL_IO18]);
            if (rail_enable[RAIL_CORE]) check_bit("io18 mem before core", 1'b1,
                rail_good[RAIL_IO18] & rail_good[RAIL_MEM]);
            if (rail_enable[RAIL_ACCEL])
                check_bit("core before accel", 1'b1, rail_good[RAIL_CORE]);
            if (!is_3v3) check_bit("dvio paired with io18", rail_enable[RAIL_IO18],
                rail_enable[RAIL_DVIO]);
            else if (rail_enable[RAIL_DVIO]) check_bit("accel before dvio", 1'b1,
                rail_good[RAIL_ACCEL]);
        end
        if (n >= 3000) timed_out("rail ramp");
        power_on_req = 1'b0;
        check_bit("por low during ramp", 1'b0, por_n);
        check_bit("warm reset low during ramp", 1'b0, warm_reset_n);
    endtask : power_up

    task automatic scen_reset_release;
        int n;
        int setup;
        int hold;
        tick(200);
        check_bit("por held without oscillator", 1'b0, por_n);
        osc_stable = 1'b1;
        n = 0;
        setup = 0;
        while (por_n !== 1'b1 && n < 1000) begin
            tick(1);
            n++;
            if (por_n === 1'b0 && boot_strap_oe === 1'b1
                && boot_strap_pins === boot_value) setup++;
        end
        if (n >= 1000) timed_out("por release");
        check_count("por low after osc stable", 12 * P_CYC, 13 * P_CYC + 4, n);
        check_bit("warm reset released with por", 1'b1, warm_reset_n);
        check_word("strap value at release", boot_value, boot_strap_pins);
        check_count("strap setup", 2 * P_CYC, 1000, setup);
        hold = 0;
        while (boot_strap_oe === 1'b1 && boot_strap_pins === boot_value && hold < 1000) begin
            tick(1);
            hold++;
        end
        check_count("strap hold", 15 * P_CYC, 999, hold);
        wait_running();
    endtask : scen_reset_release

    // Counts cycles from por assertion to the first change of the rail enables.
    task automatic lead_after_por(output int n);
        n = 0;
        while (por_n !== 1'b0 && n < 10) begin
            tick(1);
            n++;
        end
        check_bit("por asserted before rails fall", 1'b0, por_n);
        n = 0;
        while (rail_enable === 6'h3F && n < 20000) begin
            tick(1);
            n++;
        end
    endtask : lead_after_por

    task automatic scen_abrupt;
        int n;
        input_power_lost = 1'b1;
        lead_after_por(n);
        check_count("por lead abrupt", POR_LEAD_CYC, POR_LEAD_CYC + 4, n);
        check_rails("rails left after abrupt drop", 6'h21, rail_enable);
        n = 0;
        while (rail_enable !== RAILS_OFF && n < GROUP2_CYC) begin
            tick(1);
            n++;
        end
        check_count("io18 falls after accel and core", 1, GROUP2_CYC - 1, n);
        check_bit("mem discharge in time", 1'b0, mem_late);
        input_power_lost = 1'b0;
        tick(4);
    endtask : scen_abrupt

    task automatic scen_normal_off;
        int n;
        wait_running();
        power_off_req = 1'b1;
        lead_after_por(n);
        check_count("por lead normal", POR_LEAD_CYC, POR_LEAD_CYC + 4, n);
        check_rails("3v3 dual rails fall first", 6'h1F, rail_enable);
    endtask : scen_normal_off

    initial begin
        clock = 1'b0;
        forever #4 clock = ~clock;
    end

    initial begin
        miscompares      = 0;
        tests_run        = 0;
        nrst             = 1'b0;
        power_on_req     = 1'b0;
        power_off_req    = 1'b0;
        input_power_lost = 1'b0;
        dvio_is_3v3      = 1'b0;
        osc_stable       = 1'b0;
        slow_rails       = 1'b1;
        p_cycles         = 32'(P_CYC);
        boot_value       = 16'hA5C3;
        repeat (5) @(posedge clock);
        #1;
        nrst = 1'b1;
        tick(4);
        power_up(1'b0, 1'b1);
        scen_reset_release();
        scen_abrupt();
        boot_value = 16'h5A3C;
        power_up(1'b1, 1'b0);
        scen_normal_off();
        wrap_up();
    end
endmodule : supply_rail_reset_sequencer_tb
